// ### ebh_consts.svh
// Function
// - grant answers an asserted bus request
// - test mode grant lets outsider reach registers
// - otherwise halt memory, float memory outputs
// - direction asserts on read with select
// - slot one high and low selects
// - drive attribute select and I/O strobes
// - wait input taken from the accessed slot only
// - slot two high and low selects
`ifndef EBH_CONSTS_SVH
`define EBH_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define EBH_CLK_PERIOD_NS 100
`define EBH_STROBE_MIN_NS 300
`define EBH_SETUP_MIN_NS 100
`define EBH_STROBE_CYCLES \
    ((`EBH_STROBE_MIN_NS + `EBH_CLK_PERIOD_NS - 1) / `EBH_CLK_PERIOD_NS)
`define EBH_SETUP_CYCLES \
    ((`EBH_SETUP_MIN_NS + `EBH_CLK_PERIOD_NS - 1) / `EBH_CLK_PERIOD_NS)

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define EBH_CS_HI_BIT 1
`define EBH_CS_LO_BIT 0
`define EBH_CS_IDLE 2'h3
`define EBH_CNT_WIDTH 4

`endif

// ### ebh_pkg.sv
package ebh_pkg;

    typedef enum logic [1:0] {
        EBH_G_IDLE,
        EBH_G_DRAIN,
        EBH_G_GRANT
    } ebh_grant_state_t;

    typedef enum logic [2:0] {
        EBH_C_IDLE,
        EBH_C_SETUP,
        EBH_C_STROBE,
        EBH_C_WAIT,
        EBH_C_HOLD
    } ebh_card_state_t;

endpackage

// ### ebh_slot_model.sv
`timescale 1ns/1ps
module ebh_slot_model (
    input wire logic clock_i,
    input wire logic [3:0] stall_i,
    input wire logic [1:0] cs1_n_i,
    input wire logic [1:0] cs2_n_i,
    input wire logic strobe_n_i,
    output logic wait1_n_o,
    output logic wait2_n_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge clock_i) begin
        if (strobe_n_i) begin
            cnt_q <= stall_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // wait from the selected slot only, pulled high otherwise
    assign wait1_n_o = !(!strobe_n_i && cnt_q != 4'h0 && cs1_n_i != 2'h3);
    assign wait2_n_o = !(!strobe_n_i && cnt_q != 4'h0 && cs2_n_i != 2'h3);
endmodule

// ### ebh_top.sv
`timescale 1ns/1ps
`include "ebh_consts.svh"

module ebh_top #(
    parameter int STROBE_CYCLES = `EBH_STROBE_CYCLES,
    parameter int SETUP_CYCLES = `EBH_SETUP_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ext_bus_request_n_i,
    input wire logic test_register_access_select_i,
    input wire logic test_access_enable_i,
    input wire logic mem_busy_i,
    input wire logic card_req_i,
    input wire logic card_slot_i,
    input wire logic card_read_i,
    input wire logic card_io_i,
    input wire logic card_attr_i,
    input wire logic card_hi_i,
    input wire logic card_lo_i,
    input wire logic slot1_wait_n_i,
    input wire logic slot2_wait_n_i,
    output logic ext_bus_grant_n_o,
    output logic test_access_active_o,
    output logic mem_halt_o,
    output logic mem_drive_oe_n_o,
    output logic card_busy_o,
    output logic card_done_o,
    output logic [1:0] slot1_chip_selects_n_o,
    output logic [1:0] slot2_chip_selects_n_o,
    output logic slot_attribute_space_select_n_o,
    output logic slot_io_read_strobe_n_o,
    output logic slot_io_write_strobe_n_o,
    output logic slot_buffer_direction_n_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [1:0] cs_code(input logic hi, input logic lo);
        logic [1:0] code;
        code = `EBH_CS_IDLE;
        code[`EBH_CS_HI_BIT] = ~hi;
        code[`EBH_CS_LO_BIT] = ~lo;
        return code;
    endfunction

    function automatic logic test_mode(input logic sel, input logic en);
        return sel & en;
    endfunction

    // ----------------------------------------
    // bus handover
    // ----------------------------------------
    ebh_pkg::ebh_grant_state_t g_state_q;
    ebh_pkg::ebh_grant_state_t g_state_d;
    ebh_pkg::ebh_card_state_t c_state_q;
    ebh_pkg::ebh_card_state_t c_state_d;
    logic req_active;
    logic tmode;
    logic card_idle;

    assign req_active = ~ext_bus_request_n_i;
    assign tmode = test_mode(test_register_access_select_i, test_access_enable_i);
    assign card_idle = (c_state_q == ebh_pkg::EBH_C_IDLE);

    always_comb begin
        g_state_d = g_state_q;
        case (g_state_q)
            ebh_pkg::EBH_G_IDLE: begin
                if (req_active) begin
                    g_state_d = ebh_pkg::EBH_G_DRAIN;
                end
            end
            ebh_pkg::EBH_G_DRAIN: begin
                if (!req_active) begin
                    g_state_d = ebh_pkg::EBH_G_IDLE;
                end else if (tmode || (!mem_busy_i && card_idle)) begin
                    g_state_d = ebh_pkg::EBH_G_GRANT;
                end
            end
            ebh_pkg::EBH_G_GRANT: begin
                if (!req_active) begin
                    g_state_d = ebh_pkg::EBH_G_IDLE;
                end
            end
            default: begin
                g_state_d = ebh_pkg::EBH_G_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            g_state_q <= ebh_pkg::EBH_G_IDLE;
        end else begin
            g_state_q <= g_state_d;
        end
    end

    // grant only once the outsider may drive
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ext_bus_grant_n_o <= 1'b1;
        end else begin
            ext_bus_grant_n_o <= ~(g_state_d == ebh_pkg::EBH_G_GRANT);
        end
    end

    // test access path to internal registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            test_access_active_o <= 1'b0;
        end else begin
            test_access_active_o <= (g_state_d == ebh_pkg::EBH_G_GRANT) && tmode;
        end
    end

    // halt own memory cycles and float memory outputs, except in test mode
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mem_halt_o <= 1'b0;
            mem_drive_oe_n_o <= 1'b0;
        end else begin
            mem_halt_o <= (g_state_d != ebh_pkg::EBH_G_IDLE) && !tmode;
            mem_drive_oe_n_o <= (g_state_d == ebh_pkg::EBH_G_GRANT) && !tmode;
        end
    end

    // ----------------------------------------
    // card slot access
    // ----------------------------------------
    logic [`EBH_CNT_WIDTH-1:0] cnt_q;
    logic slot_q;
    logic read_q;
    logic io_q;
    logic attr_q;
    logic hi_q;
    logic lo_q;
    logic wait_sel;
    logic start;
    logic cnt_done;

    assign start = card_req_i && (g_state_q == ebh_pkg::EBH_G_IDLE) && !req_active;
    assign wait_sel = slot_q ? ~slot2_wait_n_i : ~slot1_wait_n_i;
    assign cnt_done = (cnt_q == '0);

    always_comb begin
        c_state_d = c_state_q;
        case (c_state_q)
            ebh_pkg::EBH_C_IDLE: begin
                if (start) begin
                    c_state_d = ebh_pkg::EBH_C_SETUP;
                end
            end
            ebh_pkg::EBH_C_SETUP: begin
                if (cnt_done) begin
                    c_state_d = ebh_pkg::EBH_C_STROBE;
                end
            end
            ebh_pkg::EBH_C_STROBE: begin
                if (cnt_done) begin
                    c_state_d = wait_sel ? ebh_pkg::EBH_C_WAIT : ebh_pkg::EBH_C_HOLD;
                end
            end
            ebh_pkg::EBH_C_WAIT: begin
                if (!wait_sel) begin
                    c_state_d = ebh_pkg::EBH_C_HOLD;
                end
            end
            ebh_pkg::EBH_C_HOLD: begin
                c_state_d = ebh_pkg::EBH_C_IDLE;
            end
            default: begin
                c_state_d = ebh_pkg::EBH_C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            c_state_q <= ebh_pkg::EBH_C_IDLE;
        end else begin
            c_state_q <= c_state_d;
        end
    end

    // phase length counter
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (c_state_q == ebh_pkg::EBH_C_IDLE && start) begin
            cnt_q <= `EBH_CNT_WIDTH'(SETUP_CYCLES - 1);
        end else if (c_state_q == ebh_pkg::EBH_C_SETUP && cnt_done) begin
            cnt_q <= `EBH_CNT_WIDTH'(STROBE_CYCLES - 1);
        end else if (!cnt_done) begin
            cnt_q <= cnt_q - `EBH_CNT_WIDTH'(1);
        end
    end

    // access attributes caught at start
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            slot_q <= 1'b0;
            read_q <= 1'b0;
            io_q <= 1'b0;
            attr_q <= 1'b0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else if (c_state_q == ebh_pkg::EBH_C_IDLE && start) begin
            slot_q <= card_slot_i;
            read_q <= card_read_i;
            io_q <= card_io_i;
            attr_q <= card_attr_i;
            hi_q <= card_hi_i;
            lo_q <= card_lo_i;
        end
    end

    // ----------------------------------------
    // slot outputs
    // ----------------------------------------
    logic sel_d;
    logic strobe_d;
    logic [1:0] cs_d;

    assign sel_d = (c_state_d != ebh_pkg::EBH_C_IDLE) && (c_state_q != ebh_pkg::EBH_C_IDLE);
    assign strobe_d = (c_state_d == ebh_pkg::EBH_C_STROBE) ||
                      (c_state_d == ebh_pkg::EBH_C_WAIT);
    assign cs_d = sel_d ? cs_code(hi_q, lo_q) : `EBH_CS_IDLE;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            slot1_chip_selects_n_o <= `EBH_CS_IDLE;
            slot2_chip_selects_n_o <= `EBH_CS_IDLE;
        end else begin
            slot1_chip_selects_n_o <= slot_q ? `EBH_CS_IDLE : cs_d;
            slot2_chip_selects_n_o <= slot_q ? cs_d : `EBH_CS_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            slot_attribute_space_select_n_o <= 1'b1;
            slot_io_read_strobe_n_o <= 1'b1;
            slot_io_write_strobe_n_o <= 1'b1;
        end else begin
            slot_attribute_space_select_n_o <= ~(sel_d && (attr_q || io_q));
            slot_io_read_strobe_n_o <= ~(strobe_d && io_q && read_q);
            slot_io_write_strobe_n_o <= ~(strobe_d && io_q && !read_q);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            slot_buffer_direction_n_o <= 1'b1;
        end else begin
            slot_buffer_direction_n_o <= ~((cs_d != `EBH_CS_IDLE) && read_q);
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            card_busy_o <= 1'b0;
            card_done_o <= 1'b0;
        end else begin
            card_busy_o <= (c_state_d != ebh_pkg::EBH_C_IDLE);
            card_done_o <= (c_state_q == ebh_pkg::EBH_C_HOLD);
        end
    end

endmodule

// ### ebh_top_asserts.sv
`timescale 1ns/1ps
module ebh_top_asserts (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ext_bus_request_n_i,
    input wire logic slot1_wait_n_i,
    input wire logic slot2_wait_n_i,
    input wire logic ext_bus_grant_n_o,
    input wire logic test_access_active_o,
    input wire logic mem_halt_o,
    input wire logic mem_drive_oe_n_o,
    input wire logic card_done_o,
    input wire logic [1:0] slot1_chip_selects_n_o,
    input wire logic [1:0] slot2_chip_selects_n_o,
    input wire logic slot_attribute_space_select_n_o,
    input wire logic slot_io_read_strobe_n_o,
    input wire logic slot_io_write_strobe_n_o,
    input wire logic slot_buffer_direction_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic s1 = slot1_chip_selects_n_o != 2'h3;
    wire logic s2 = slot2_chip_selects_n_o != 2'h3;
    wire logic stb = !slot_io_read_strobe_n_o || !slot_io_write_strobe_n_o;
    wire logic wt = s1 ? !slot1_wait_n_i : !slot2_wait_n_i;
    a_grant_delay: assert property ($fell(ext_bus_grant_n_o) |->
        !$past(ext_bus_request_n_i) && !$past(ext_bus_request_n_i, 2)) else $error("early grant");
    a_grant_release: assert property ((!ext_bus_grant_n_o && ext_bus_request_n_i) |->
        ##[1:2] ext_bus_grant_n_o) else $error("grant not released");
    a_float_mem: assert property ((!ext_bus_grant_n_o && !test_access_active_o) |->
        mem_halt_o && mem_drive_oe_n_o) else $error("memory not floated");
    a_test_grant: assert property (test_access_active_o |->
        !ext_bus_grant_n_o && !mem_halt_o) else $error("test access without grant");
    a_dir_read: assert property (!slot_buffer_direction_n_o |-> s1 || s2)
        else $error("direction without select");
    a_slot_excl: assert property (!(s1 && s2)) else $error("both slots selected");
    a_strobe_sel: assert property (stb |-> (s1 || s2) && !slot_attribute_space_select_n_o
        && !(!slot_io_read_strobe_n_o && !slot_io_write_strobe_n_o)) else $error("bad strobe");
    a_wait_hold: assert property ((stb && wt) |=> stb) else $error("wait ignored");
    a_done_pulse: assert property (card_done_o |=> !card_done_o)
        else $error("done too long");
endmodule

// ### tb_external_bus_handover_card_strobes.sv
`timescale 1ns/1ps
module tb_external_bus_handover_card_strobes;
    localparam int STB = 3;
    logic clk = 0, rst_n = 0, req_n = 1, sel = 0, en = 0, mbusy = 0, creq = 0;
    logic cslot = 0, crd = 0, cio = 0, cattr = 0, chi = 0, clo = 0;
    logic [3:0] stall = 4'h0;
    logic w1_n, w2_n, gnt_n, tact, halt, oe_n, busy, done, attr_n, iord_n, iowr_n, dir_n;
    logic [1:0] cs1_n, cs2_n;
    int n_fail = 0;
    int n_tests = 0;
    initial forever #50 clk = ~clk;
    ebh_slot_model SLOT (.clock_i(clk), .stall_i(stall), .cs1_n_i(cs1_n), .cs2_n_i(cs2_n),
        .strobe_n_i(iord_n & iowr_n), .wait1_n_o(w1_n), .wait2_n_o(w2_n));
    ebh_top #(.STROBE_CYCLES(STB), .SETUP_CYCLES(1)) DUT (
        .clock_i(clk),
        .rst_n_i(rst_n),
        .ext_bus_request_n_i(req_n),
        .test_register_access_select_i(sel),
        .test_access_enable_i(en),
        .mem_busy_i(mbusy),
        .card_req_i(creq),
        .card_slot_i(cslot),
        .card_read_i(crd),
        .card_io_i(cio),
        .card_attr_i(cattr),
        .card_hi_i(chi),
        .card_lo_i(clo),
        .slot1_wait_n_i(w1_n),
        .slot2_wait_n_i(w2_n),
        .ext_bus_grant_n_o(gnt_n),
        .test_access_active_o(tact),
        .mem_halt_o(halt),
        .mem_drive_oe_n_o(oe_n),
        .card_busy_o(busy),
        .card_done_o(done),
        .slot1_chip_selects_n_o(cs1_n),
        .slot2_chip_selects_n_o(cs2_n),
        .slot_attribute_space_select_n_o(attr_n),
        .slot_io_read_strobe_n_o(iord_n),
        .slot_io_write_strobe_n_o(iowr_n),
        .slot_buffer_direction_n_o(dir_n)
    );
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic hand(input logic s, input logic e, input logic mb);
        int k;
        logic tm;
        tm = s & e;
        k = 0;
        @(posedge clk);
        sel <= s;
        en <= e;
        mbusy <= mb;
        req_n <= 1'h0;
        @(posedge clk) creq <= 1'h1;
        @(posedge clk) creq <= 1'h0;
        repeat (4) @(posedge clk);
        if (mb && !tm) begin
            @(negedge clk) chk("grant_busy", 4'h1, {3'h0, gnt_n});
            @(posedge clk) mbusy <= 1'h0;
        end
        while (gnt_n !== 1'h0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk) chk("grant", 4'h0, {3'h0, gnt_n});
        chk("mode", {tm, !tm, !tm, 1'h0}, {tact, halt, oe_n, busy});
        @(posedge clk) req_n <= 1'h1;
        mbusy <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk) chk("release", 4'h8, {gnt_n, tact, halt, oe_n});
    endtask
    task automatic card(input logic [2:0] i);
        int n, k;
        logic s, rd, io, at, h, l;
        s = i[0];
        rd = i[1];
        io = i[2];
        at = i[1] ^ i[0];
        h = !i[0] | i[2];
        l = i[0] | i[1];
        n = 0;
        k = 0;
        @(posedge clk);
        {cslot, crd, cio, cattr, chi, clo, creq} <= {s, rd, io, at, h, l, 1'h1};
        stall <= (i > 3'h5) ? 4'h6 : 4'h0;
        @(posedge clk) creq <= 1'h0;
        while (done !== 1'h1 && k < 40) begin
            @(negedge clk);
            k++;
            if (k == 1) begin
                chk("busy", 4'h1, {3'h0, busy});
                chk("cs_setup", 4'hF, {cs1_n, cs2_n});
                chk("attr_dir_setup", 4'h3, {2'h0, attr_n, dir_n});
                chk("strobe_setup", 4'h3, {2'h0, iord_n, iowr_n});
            end else if (busy === 1'h1 && done !== 1'h1) begin
                chk("cs", s ? {2'h3, ~h, ~l} : {~h, ~l, 2'h3}, {cs1_n, cs2_n});
                chk("attr_dir", {2'h0, !(at | io), !rd}, {2'h0, attr_n, dir_n});
                chk("strobe", 4'h3, {2'h0, iord_n | (io & rd), iowr_n | (io & !rd)});
                n += !(iord_n & iowr_n);
            end
        end
        chk("done", 4'h1, {3'h0, done});
        chk("strobe_len", 4'h1, {3'h0, io ? (i > 3'h5 ? n > STB : n == STB) : n == 0});
    endtask
    task automatic mid_reset();
        @(posedge clk) req_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk) chk("mid_reset", 4'h8, {gnt_n, tact, halt, oe_n});
        chk("mid_reset_cs", 4'hF, {cs1_n, cs2_n});
        @(posedge clk) rst_n <= 1'h1;
        req_n <= 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk) chk("after_reset", 4'h8, {gnt_n, tact, halt, oe_n});
        chk("after_reset_busy", 4'h0, {3'h0, busy});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) chk("reset_cs", 4'hF, {cs1_n, cs2_n});
        chk("reset_strb", 4'hF, {attr_n, iord_n, iowr_n, dir_n});
        @(posedge clk) rst_n <= 1'h1;
        @(negedge clk) chk("reset_bus", 4'h8, {gnt_n, tact, halt, oe_n});
        hand(1'h0, 1'h0, 1'h0);
        hand(1'h0, 1'h0, 1'h1);
        hand(1'h1, 1'h1, 1'h1);
        hand(1'h1, 1'h0, 1'h1);
        hand(1'h0, 1'h1, 1'h0);
        mid_reset();
        for (int i = 0; i < 8; i++) card(i[2:0]);
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
bind ebh_top ebh_top_asserts u_chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ext_bus_request_n_i(ext_bus_request_n_i),
    .slot1_wait_n_i(slot1_wait_n_i),
    .slot2_wait_n_i(slot2_wait_n_i),
    .ext_bus_grant_n_o(ext_bus_grant_n_o),
    .test_access_active_o(test_access_active_o),
    .mem_halt_o(mem_halt_o),
    .mem_drive_oe_n_o(mem_drive_oe_n_o),
    .card_done_o(card_done_o),
    .slot1_chip_selects_n_o(slot1_chip_selects_n_o),
    .slot2_chip_selects_n_o(slot2_chip_selects_n_o),
    .slot_attribute_space_select_n_o(slot_attribute_space_select_n_o),
    .slot_io_read_strobe_n_o(slot_io_read_strobe_n_o),
    .slot_io_write_strobe_n_o(slot_io_write_strobe_n_o),
    .slot_buffer_direction_n_o(slot_buffer_direction_n_o)
);
